// *** src/sfp_fifo.sv ***
// first-in first-out word store with valid/ready on both sides
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
module sfp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  sfp_stream_if.snk wr,
  sfp_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // word storage
  logic [AW-1:0] wp; // write pointer
  logic [AW-1:0] rp; // read pointer
  logic [AW:0] cnt; // words held
  logic push; // word enters
  logic pop; // word leaves

  // pointer step with wrap, works for any depth
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // honest full and empty flags drive the handshakes
  assign wr.ready = (cnt != (AW + 1)'(DEPTH));
  assign rd.valid = (cnt != '0);
  assign rd.data = mem[rp];
  assign push = wr.valid & wr.ready;
  assign pop = rd.valid & rd.ready;

  ////////////////////////////////////////////////////////////////////////////
  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= wr.data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= step(wp);
      end
      if (pop) begin
        rp <= step(rp);
      end
      if (push && !pop) begin
        cnt <= cnt + 1'b1;
      end else if (pop && !push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule

// *** src/sfp_pkg.sv ***
// shared constants and types for the framed serial port
// assumes a 100 MHz system clock; sfp_port and the bench import the whole package, sfp_stream_if names sfp_pkg::WORD_W
package sfp_pkg;
  // data word and buffering
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] BIT_LAST = 4'hf;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // timing: system clock and serial clock half period
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_HALF_NS = 80;
  // a least time, so round up to whole cycles
  localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYCLES - 1);
  localparam logic [3:0] SCK_CNT_RESET = 4'h0;

  // port sequencer states, gray along idle -> sync -> shift
  typedef enum logic [1:0] {
    SFP_IDLE  = 2'b00,
    SFP_SYNC  = 2'b01,
    SFP_SHIFT = 2'b11
  } sfp_state_t;
endpackage

// *** src/sfp_port.sv ***
// serial peripheral port: master or slave, optional framed mode with sync pulse
// assumes config inputs come from logic on CLK; pin inputs are asynchronous
//
// Summary of operation
// (RQ1) framed mode with select pin is invalid
// (RQ2) framed master keeps serial clock running continuously
// (RQ3) frame sync on select line starts each frame
// (RQ4) sample phase acts only in master operation
// (RQ5) sample phase honoured if set with/after master
// (RQ6) transfer start moves buffer to shifter, empties buffer
// (RQ7) controller preloads buffer before each transfer
// (RQ8) sync lasts one clock, right before data
`timescale 1ns/1ps
module sfp_port
  import sfp_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic MASTER_OPERATION_ENABLE,
  input wire logic FRAMED_MODE_ENABLE,
  input wire logic SLAVE_SELECT_PIN_ENABLE,
  input wire logic INPUT_SAMPLE_PHASE,
  input wire logic [15:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic TX_BUFFER_EMPTY,
  output logic [15:0] RX_DATA,
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic RX_OVERFLOW,
  input wire logic RX_OVERFLOW_CLEAR,
  output logic CONFIG_INVALID,
  output logic BUSY,
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  input wire logic SS_IN,
  output logic SS_OUT,
  output logic SS_OE
);
  sfp_stream_if wr_if (); // user side into the fifo
  sfp_stream_if rd_if (); // fifo into the transmit buffer

  logic sck_m, sck_s, sck_d; // serial clock synchroniser and edge history
  logic sdi_m, sdi_s; // data-in synchroniser
  logic ss_m, ss_s; // select/sync synchroniser
  logic smp_prev; // sample phase seen last cycle
  logic smp_eff; // sample phase as actually applied
  logic role_d; // master enable seen last cycle
  logic [3:0] half_cnt; // serial clock half-period counter
  logic sck_reg; // generated serial clock
  logic running; // generated clock is toggling
  logic wrap; // half period elapsed
  logic rise_ev, fall_ev; // serial clock edges of the active role
  logic sample_ev; // moment of capturing input data
  logic last_now; // final bit captured in this cycle
  logic selected; // slave is addressed
  sfp_state_t state, next_state; // sequencer
  logic do_load, do_finish, sync_on, sync_off; // sequencer actions
  logic [15:0] tx_buf; // transmit buffer, one word
  logic tx_full; // transmit buffer holds a word
  logic [15:0] tx_sh; // transmit shifter, msb first
  logic [15:0] rx_sh; // receive shifter
  logic [3:0] bit_cnt; // bits captured in this word
  logic word_end; // all bits in, waiting for closing edge
  logic ss_out; // frame sync drive
  logic [15:0] rx_word; // completed receive word

  ////////////////////////////////////////////////////////////////////////////
  // transmit fifo; its ready is the user's back-pressure
  assign wr_if.valid = TX_VALID;
  assign wr_if.data = TX_DATA;
  assign TX_READY = wr_if.ready;
  assign rd_if.ready = !tx_full;

  sfp_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rstn(RSTN),
    .wr(wr_if),
    .rd(rd_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only the second stage and later are read
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_d <= 1'b0;
      sdi_m <= 1'b0;
      sdi_s <= 1'b0;
      ss_m <= 1'b1;
      ss_s <= 1'b1;
    end else begin
      sck_m <= SCK_IN;
      sck_s <= sck_m;
      sck_d <= sck_s;
      sdi_m <= SDI;
      sdi_s <= sdi_m;
      ss_m <= SS_IN;
      ss_s <= ss_m;
    end
  end

  // sample phase arms only on a rise while master is on, so a bit left
  // set from before master enable is ignored until rewritten
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      smp_prev <= 1'b0;
      smp_eff <= 1'b0;
      role_d <= 1'b0;
    end else begin
      smp_prev <= INPUT_SAMPLE_PHASE;
      role_d <= MASTER_OPERATION_ENABLE;
      if (!MASTER_OPERATION_ENABLE || !INPUT_SAMPLE_PHASE) begin
        smp_eff <= 1'b0; // [RQ4]
      end else if (!smp_prev) begin
        smp_eff <= 1'b1; // [RQ5]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial clock generator; free running whenever framed master is on
  assign running = MASTER_OPERATION_ENABLE &&
                   (FRAMED_MODE_ENABLE || state != SFP_IDLE); // [RQ2]
  assign wrap = running && (half_cnt == SCK_HALF_LAST);

  always_ff @(posedge CLK) begin
    if (!RSTN || !running) begin
      half_cnt <= SCK_CNT_RESET;
      sck_reg <= 1'b0;
    end else if (wrap) begin
      half_cnt <= SCK_CNT_RESET;
      sck_reg <= !sck_reg;
    end else begin
      half_cnt <= half_cnt + 1'b1;
    end
  end

  // edges come from our own clock as master, from the pin as slave
  assign rise_ev = MASTER_OPERATION_ENABLE ? (wrap && !sck_reg) : (sck_s && !sck_d);
  assign fall_ev = MASTER_OPERATION_ENABLE ? (wrap && sck_reg) : (!sck_s && sck_d);
  assign sample_ev = smp_eff ? fall_ev : rise_ev; // [RQ4]
  assign last_now = sample_ev && (state == SFP_SHIFT) && (bit_cnt == BIT_LAST);
  // select pin is active low; without it a non-framed slave is always on
  assign selected = SLAVE_SELECT_PIN_ENABLE ? !ss_s : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer decisions
  always_comb begin
    next_state = state;
    do_load = 1'b0;
    do_finish = 1'b0;
    sync_on = 1'b0;
    sync_off = 1'b0;
    case (state)
      SFP_IDLE: begin
        if (MASTER_OPERATION_ENABLE) begin
          // master waits for a buffered word
          if (tx_full && FRAMED_MODE_ENABLE && fall_ev) begin
            next_state = SFP_SYNC;
            sync_on = 1'b1; // [RQ3]
          end else if (tx_full && !FRAMED_MODE_ENABLE) begin
            next_state = SFP_SHIFT;
            do_load = 1'b1; // [RQ6]
          end
        end else if (FRAMED_MODE_ENABLE) begin
          // slave: sync seen high at a rise opens the frame
          if (rise_ev && ss_s) begin
            next_state = SFP_SYNC; // [RQ3]
          end
        end else if (selected) begin
          next_state = SFP_SHIFT;
          do_load = 1'b1; // [RQ6]
        end
      end
      SFP_SYNC: begin
        // sync spans one full clock, data starts at its closing fall
        if (fall_ev) begin
          next_state = SFP_SHIFT;
          do_load = 1'b1; // [RQ6]
          sync_off = 1'b1; // [RQ8]
        end
      end
      SFP_SHIFT: begin
        if (!MASTER_OPERATION_ENABLE && !FRAMED_MODE_ENABLE && !selected) begin
          next_state = SFP_IDLE; // deselect aborts the word
        end else if (fall_ev && (word_end || last_now)) begin
          do_finish = 1'b1;
          if (MASTER_OPERATION_ENABLE) begin
            if (FRAMED_MODE_ENABLE && tx_full) begin
              next_state = SFP_SYNC;
              sync_on = 1'b1; // [RQ3]
            end else begin
              next_state = SFP_IDLE;
            end
          end else if (FRAMED_MODE_ENABLE) begin
            next_state = SFP_IDLE;
          end else begin
            do_load = 1'b1; // [RQ6]
          end
        end
      end
      default: begin
        next_state = SFP_IDLE;
      end
    endcase
    // a role change mid-word drops the word
    if (MASTER_OPERATION_ENABLE != role_d) begin
      next_state = SFP_IDLE;
      do_load = 1'b0;
      do_finish = 1'b0;
      sync_on = 1'b0;
    end
  end

  assign rx_word = last_now ? {rx_sh[14:0], sdi_s} : rx_sh;

  ////////////////////////////////////////////////////////////////////////////
  // state, buffer and shifters
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state <= SFP_IDLE;
      tx_buf <= WORD_RESET;
      tx_full <= 1'b0;
      tx_sh <= WORD_RESET;
      rx_sh <= WORD_RESET;
      bit_cnt <= BIT_FIRST;
      word_end <= 1'b0;
      ss_out <= 1'b0;
    end else begin
      state <= next_state;
      if (do_load) begin
        // an empty buffer sends zeros rather than stalling the clock
        tx_sh <= tx_full ? tx_buf : WORD_RESET; // [RQ6]
        tx_full <= 1'b0; // [RQ6]
      end else if (rd_if.valid && !tx_full) begin
        tx_buf <= rd_if.data;
        tx_full <= 1'b1;
      end
      if (!do_load && fall_ev && state == SFP_SHIFT) begin
        tx_sh <= {tx_sh[14:0], 1'b0};
      end
      if (do_load || next_state == SFP_IDLE) begin
        bit_cnt <= BIT_FIRST;
        word_end <= 1'b0;
      end else if (sample_ev && state == SFP_SHIFT) begin
        rx_sh <= {rx_sh[14:0], sdi_s};
        bit_cnt <= bit_cnt + 1'b1;
        word_end <= last_now && !do_finish;
      end else if (do_finish) begin
        word_end <= 1'b0;
      end
      if (sync_on) begin
        ss_out <= 1'b1; // [RQ8]
      end else if (sync_off || next_state == SFP_IDLE) begin
        ss_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive word output and overrun flag; a new overrun beats a clear
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      RX_DATA <= WORD_RESET;
      RX_VALID <= 1'b0;
      RX_OVERFLOW <= 1'b0;
    end else begin
      if (do_finish) begin
        RX_DATA <= rx_word;
        RX_VALID <= 1'b1;
      end else if (RX_READY) begin
        RX_VALID <= 1'b0;
      end
      if (do_finish && RX_VALID && !RX_READY) begin
        RX_OVERFLOW <= 1'b1;
      end else if (RX_OVERFLOW_CLEAR) begin
        RX_OVERFLOW <= 1'b0;
      end
    end
  end

  // configuration check: framing and select pin together are not supported
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      CONFIG_INVALID <= 1'b0;
    end else begin
      CONFIG_INVALID <= FRAMED_MODE_ENABLE && SLAVE_SELECT_PIN_ENABLE; // [RQ1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive; enables high while driving
  assign SCK_OUT = sck_reg;
  assign SCK_OE = MASTER_OPERATION_ENABLE;
  assign SDO = tx_sh[15];
  assign SDO_OE = MASTER_OPERATION_ENABLE || FRAMED_MODE_ENABLE || selected;
  assign SS_OUT = ss_out;
  assign SS_OE = MASTER_OPERATION_ENABLE && FRAMED_MODE_ENABLE; // [RQ3]
  assign TX_BUFFER_EMPTY = !tx_full; // [RQ7]
  assign BUSY = (state != SFP_IDLE);
endmodule

// *** src/sfp_stream_if.sv ***
// valid/ready word stream between the port and its transmit fifo
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface sfp_stream_if #(parameter int W = sfp_pkg::WORD_W);
  logic valid; // word offered
  logic ready; // word accepted this cycle when valid
  logic [W-1:0] data; // the word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** verification/sfp_peer.sv ***
// far side model: slave while the port masters, master while it is slave
// assumes pins wired straight; framed slave runs use the frame task,
// select-pin slave runs the word task
`timescale 1ns/1ps
module sfp_peer (
  input wire logic MAST,
  input wire logic SCK_OUT,
  input wire logic SDO,
  input wire logic SS_OUT,
  output logic SCK_IN,
  output logic SDI,
  output logic SS_IN
);
  logic [15:0] tx = 16'h0000; // outgoing word, msb on the line
  logic [15:0] rx = 16'h0000; // bits seen from the port
  logic [15:0] pat = 16'h0000; // word reloaded at each sync
  logic adv = 1'b0; // sampled, so shift at next fall
  wire logic sck = MAST ? SCK_OUT : SCK_IN;
  wire logic syn = MAST ? SS_OUT : SS_IN;
  assign SDI = tx[15];
  initial begin
    SCK_IN = 1'b0;
    SS_IN = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // sync rise reloads, data rise samples
  always @(posedge sck) begin
    if (syn) begin // frame start
      tx <= pat; // ready before the frame
      adv <= 1'b0;
    end else begin
      rx <= {rx[14:0], SDO};
      adv <= 1'b1;
    end
  end
  // shift only after a sample, so the load fall keeps the msb
  always @(negedge sck) begin
    if (adv) begin
      tx <= {tx[14:0], ~tx[15]}; // toggling fill, never a stale copy
      adv <= 1'b0;
    end
  end
  task automatic sel(input logic v);
    SS_IN = v;
  endtask
  // one sync period then sixteen bit periods, off the CLK phase
  task automatic frame();
    #3;
    SS_IN = 1'b1; // sync high across one rise
    repeat (17) begin
      #80 SCK_IN = 1'b1;
      #80 SCK_IN = 1'b0;
      SS_IN = 1'b0;
    end
  endtask
  // one word under a low select, sixteen bit periods, off the CLK phase;
  // select is released a half period after the last fall so the port sees it
  task automatic word();
    #3;
    SS_IN = 1'b0;
    repeat (16) begin
      #80 SCK_IN = 1'b1;
      #80 SCK_IN = 1'b0;
    end
    #80 SS_IN = 1'b1;
  endtask
endmodule

// *** verification/sfp_port_bench.sv ***
// self-checking bench for the framed serial port
// assumes the peer model on the pins; inputs move on falling CLK
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, a); end end
`define WAITF(c) begin k = 0; while (!(c) && k < 600) begin @(negedge clk); k++; end \
  if (!(c)) begin miscompares++; $display("Error wait expected 1 seen 0"); end end
module sfp_port_bench
  import sfp_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, mast = 1'b0, frm = 1'b0, slave_select_pin_enable = 1'b1, input_sample_phase = 1'b0;
  logic tx_valid = 1'b0, rx_ready = 1'b0, ovc = 1'b0;
  logic [15:0] tx_data = 16'h0000;
  logic [15:0] rx_data;
  logic tx_ready, tx_empty, rx_valid, cfg_bad, busy, rx_over;
  logic sck_out, sck_oe, sdo, sdo_oe, ss_out, ss_oe, sck_in, sdi, ss_in;
  int miscompares = 0, n_compared = 0, k, cyc = 0;
  always #5 clk = ~clk;
  sfp_port uut (.CLK(clk), .RSTN(rstn), .MASTER_OPERATION_ENABLE(mast),
    .FRAMED_MODE_ENABLE(frm), .SLAVE_SELECT_PIN_ENABLE(slave_select_pin_enable), .INPUT_SAMPLE_PHASE(input_sample_phase),
    .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_BUFFER_EMPTY(tx_empty),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_OVERFLOW(rx_over),
    .RX_OVERFLOW_CLEAR(ovc), .CONFIG_INVALID(cfg_bad), .BUSY(busy), .SCK_IN(sck_in),
    .SCK_OUT(sck_out), .SCK_OE(sck_oe), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe),
    .SS_IN(ss_in), .SS_OUT(ss_out), .SS_OE(ss_oe));
  sfp_peer peer (.MAST(mast), .SCK_OUT(sck_out), .SDO(sdo), .SS_OUT(ss_out),
    .SCK_IN(sck_in), .SDI(sdi), .SS_IN(ss_in));
  ////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // valid is left high; the caller drops it
  task automatic push(input logic [15:0] w);
    tx_data = w;
    tx_valid = 1'b1;
    `WAITF(tx_ready === 1'b1)
    @(negedge clk);
  endtask
  // check one word each way, then consume it
  task automatic take(input logic [15:0] dev, input logic [15:0] far);
    `WAITF(rx_valid === 1'b1)
    `CHK("rx_data", dev, rx_data)
    `CHK("peer_rx", far, peer.rx)
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
  endtask
  task automatic t_cfg();
    `CHK("tx_empty", 1'b1, tx_empty)
    `CHK("ss_out", 1'b0, ss_out)
    frm = 1'b1; // invalid mix on purpose
    @(negedge clk);
    `CHK("cfg_bad", 1'b1, cfg_bad)
    frm = 1'b0;
    @(negedge clk);
    `CHK("cfg_bad", 1'b0, cfg_bad)
  endtask
  // plain master word; sample phase set with or after master enable
  task automatic t_master(input logic s, input logic [15:0] w, input logic [15:0] p);
    mast = 1'b1;
    input_sample_phase = s;
    peer.tx = p;
    peer.adv = 1'b0;
    push(w);
    tx_valid = 1'b0;
    `WAITF(tx_empty === 1'b0)
    `WAITF(busy === 1'b1)
    `CHK("tx_empty", 1'b1, tx_empty)
    take(p, w);
    `CHK("sck_oe", 1'b1, sck_oe)
    `CHK("ss_oe", 1'b0, ss_oe)
  endtask
  task automatic t_slave();
    peer.sel(1'b0);
    mast = 1'b0;
    slave_select_pin_enable = 1'b0; // select pin off in framed mode
    frm = 1'b1;
    peer.pat = 16'h3c5a;
    push(16'h96e1);
    tx_valid = 1'b0;
    `WAITF(tx_empty === 1'b0)
    peer.frame();
    take(16'h3c5a, 16'h96e1);
  endtask
  // select-pin slave word: load on select, sample at rise, release after
  task automatic t_sel_slave();
    peer.sel(1'b1);
    frm = 1'b0;
    slave_select_pin_enable = 1'b1;
    // let the select synchroniser settle before anything is queued
    repeat (4) @(negedge clk);
    push(16'h5bd2);
    tx_valid = 1'b0;
    `WAITF(tx_empty === 1'b0)
    peer.tx = 16'he4a7;
    peer.adv = 1'b0;
    peer.word();
    take(16'he4a7, 16'h5bd2);
    repeat (2) @(negedge clk);
    `CHK("sdo_oe", 1'b0, sdo_oe)
  endtask
  // fill while nothing leaves, then drain as framed master
  task automatic t_fill();
    peer.sel(1'b1);
    frm = 1'b0;
    slave_select_pin_enable = 1'b1;
    @(negedge clk);
    for (int i = 0; i < FIFO_DEPTH + 1; i++) push(16'h1234 + 16'(i));
    tx_valid = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("tx_ready", 1'b0, tx_ready)
    peer.sel(1'b0);
    slave_select_pin_enable = 1'b0;
    frm = 1'b1;
    mast = 1'b1;
    peer.pat = 16'ha5f0;
    for (int i = 0; i < FIFO_DEPTH + 1; i++) take(16'ha5f0, 16'h1234 + 16'(i));
    `CHK("tx_empty", 1'b1, tx_empty)
    `CHK("ss_oe", 1'b1, ss_oe)
  endtask
  // two framed words and nobody reading: the second overwrites and flags overrun
  task automatic t_over();
    push(16'h0f0f);
    push(16'h7e81);
    tx_valid = 1'b0;
    `WAITF(rx_valid === 1'b1)
    peer.pat = 16'h6c93; // reloaded at the second sync
    `WAITF(rx_over === 1'b1)
    `CHK("rx_over", 1'b1, rx_over)
    ovc = 1'b1;
    @(negedge clk);
    ovc = 1'b0;
    `CHK("rx_over", 1'b0, rx_over)
    take(16'h6c93, 16'h7e81);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_cfg();
    t_master(1'b0, 16'hc3a5, 16'h5a3c);
    t_master(1'b1, 16'h0ff1, 16'h8e17);
    t_slave();
    t_sel_slave();
    t_fill();
    t_over();
    close_out();
  end
  // hang guard, well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      miscompares++;
      $display("Error %s expected %0d seen %0d", "cycle_limit", 11999, cyc);
      close_out();
    end
  end
endmodule

// *** verification/sfp_port_props.sv ***
// checker for the framed serial port, on top-level ports only
// assumes one CLK domain with RSTN synchronous, active low
`timescale 1ns/1ps
module sfp_port_props (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic MASTER_OPERATION_ENABLE,
  input wire logic FRAMED_MODE_ENABLE,
  input wire logic SLAVE_SELECT_PIN_ENABLE,
  input wire logic TX_BUFFER_EMPTY,
  input wire logic BUSY,
  input wire logic CONFIG_INVALID,
  input wire logic SCK_OUT,
  input wire logic SS_OUT,
  input wire logic RX_VALID
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  wire logic mst = MASTER_OPERATION_ENABLE; // short aliases
  wire logic frm = FRAMED_MODE_ENABLE;
  wire logic mf = mst && frm; // framed master
  ////////////////////////////////////////////////////////////
  property p_cfg_bad;
    frm && SLAVE_SELECT_PIN_ENABLE |=> CONFIG_INVALID;
  endproperty
  a_cfg_bad: assert property (p_cfg_bad) else $error("invalid mix not flagged");
  property p_cfg_ok;
    !(frm && SLAVE_SELECT_PIN_ENABLE) |=> !CONFIG_INVALID;
  endproperty
  a_cfg_ok: assert property (p_cfg_ok) else $error("flag without cause");
  // framed master clock never parks: each phase lasts 8 cycles
  property p_run_hi;
    mf && $rose(SCK_OUT) |-> ##8 ($fell(SCK_OUT) || !mf);
  endproperty
  a_run_hi: assert property (p_run_hi) else $error("clock high phase wrong");
  property p_run_lo;
    mf && $fell(SCK_OUT) |-> ##8 ($rose(SCK_OUT) || !mf);
  endproperty
  a_run_lo: assert property (p_run_lo) else $error("clock stopped");
  // sync is one serial period from a fall to the next fall
  property p_sync;
    $rose(SS_OUT) |-> (SS_OUT && !SCK_OUT)[*8] ##1 (SS_OUT && SCK_OUT)[*8] ##1 !SS_OUT;
  endproperty
  a_sync: assert property (p_sync) else $error("sync pulse shape wrong");
  property p_sync_load;
    $fell(SS_OUT) && mf |-> BUSY;
  endproperty
  a_sync_load: assert property (p_sync_load) else $error("no word after sync");
  // in framed mode busy rises at sync, before the load, so only plain master
  property p_load;
    $rose(BUSY) && mst && !frm |-> TX_BUFFER_EMPTY;
  endproperty
  a_load: assert property (p_load) else $error("buffer kept at load");
  property p_idle;
    mst && !frm && !BUSY && !$past(frm) |-> !SCK_OUT;
  endproperty
  a_idle: assert property (p_idle) else $error("plain master clock idle high");
  c_sync: cover property ($rose(SS_OUT));
  c_rx: cover property ($rose(RX_VALID));
  c_bad: cover property ($rose(CONFIG_INVALID));
endmodule
bind sfp_port sfp_port_props u_props (.CLK(CLK), .RSTN(RSTN),
  .MASTER_OPERATION_ENABLE(MASTER_OPERATION_ENABLE), .FRAMED_MODE_ENABLE(FRAMED_MODE_ENABLE),
  .SLAVE_SELECT_PIN_ENABLE(SLAVE_SELECT_PIN_ENABLE), .TX_BUFFER_EMPTY(TX_BUFFER_EMPTY),
  .BUSY(BUSY), .CONFIG_INVALID(CONFIG_INVALID), .SCK_OUT(SCK_OUT), .SS_OUT(SS_OUT),
  .RX_VALID(RX_VALID));
